//--- design/obt_transceiver.sv
// octal registered bus transceiver with an AHB-Lite control slave
`default_nettype none

module obt_transceiver #(
    parameter int PORT_W = obt_pkg::OBT_PORT_W,
    parameter int LOG_DEPTH = obt_pkg::OBT_LOG_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [obt_pkg::OBT_BUS_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [obt_pkg::OBT_BUS_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [obt_pkg::OBT_BUS_W-1:0] hrdata,
    // capture clocks from the outside logic
    input wire logic a_capture_clock,
    input wire logic b_capture_clock,
    // two-way port A
    input wire logic [PORT_W-1:0] port_a_in,
    output logic [PORT_W-1:0] port_a_out,
    output logic port_a_oe,
    // two-way port B
    input wire logic [PORT_W-1:0] port_b_in,
    output logic [PORT_W-1:0] port_b_out,
    output logic port_b_oe,
    // capture log had room for another entry one cycle earlier
    output logic cap_log_ready
);
    localparam int LOG_W = 2 * PORT_W + 2;
    localparam int SYNC_W = 2 * PORT_W + 2;
    localparam int BW = obt_pkg::OBT_BUS_W;
    localparam int DW = obt_pkg::OBT_DEC_W;
    localparam int XFER_BIT = 1; // nonseq or seq

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // both capture clocks and both ports are asynchronous to clk
    // limitation: clock levels and port data around a rise
    // must each hold about three clk cycles, else a capture
    // may be missed or store a torn value
    logic [SYNC_W-1:0] pin_s1_q;
    logic [SYNC_W-1:0] pin_s2_q;
    logic a_clk_s3_q;
    logic b_clk_s3_q;
    logic a_clk_s2;
    logic b_clk_s2;
    logic [PORT_W-1:0] live_a;
    logic [PORT_W-1:0] live_b;
    logic a_capture;
    logic b_capture;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {a_capture_clock, b_capture_clock, port_a_in, port_b_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign a_clk_s2 = pin_s2_q[SYNC_W-1];
    assign b_clk_s2 = pin_s2_q[SYNC_W-2];
    assign live_a = pin_s2_q[2*PORT_W-1:PORT_W];
    assign live_b = pin_s2_q[PORT_W-1:0];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            a_clk_s3_q <= 1'b0;
            b_clk_s3_q <= 1'b0;
        end else begin
            a_clk_s3_q <= a_clk_s2;
            b_clk_s3_q <= b_clk_s2;
        end
    end

    // port data and clock share the same two stages, so the sampled
    // data lines up with the sampled clock edge
    assign a_capture = a_clk_s2 && !a_clk_s3_q;
    assign b_capture = b_clk_s2 && !b_clk_s3_q;

    // ------------------------------------------------------------
    // storage registers
    // ------------------------------------------------------------
    logic [PORT_W-1:0] a_store_q;
    logic [PORT_W-1:0] b_store_q;
    logic a_loaded_q;
    logic b_loaded_q;

    // no reset on the data, only a flag telling software it is loaded;
    // capture ignores drive enable and direction entirely
    always_ff @(posedge clk) begin
        if (a_capture) begin
            a_store_q <= live_a;
        end
    end

    always_ff @(posedge clk) begin
        if (b_capture) begin
            b_store_q <= live_b;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            a_loaded_q <= 1'b0;
            b_loaded_q <= 1'b0;
        end else begin
            if (a_capture) begin
                a_loaded_q <= 1'b1;
            end
            if (b_capture) begin
                b_loaded_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // control register and bus slave state
    // ------------------------------------------------------------
    logic [obt_pkg::OBT_CTRL_W-1:0] ctrl_q;
    logic addr_take;
    logic wr_pend_q;
    logic [DW-1:0] waddr_q;
    logic wr_ctrl;
    logic wr_status;
    logic log_ovf_q;
    logic log_ovf_set;

    assign addr_take = hsel && hready && htrans[XFER_BIT];
    assign wr_ctrl = wr_pend_q && (waddr_q == obt_pkg::OBT_CTRL_OFS);
    assign wr_status = wr_pend_q && (waddr_q == obt_pkg::OBT_STATUS_OFS);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            waddr_q <= '0;
        end else begin
            wr_pend_q <= addr_take && hwrite;
            if (addr_take) begin
                waddr_q <= haddr[DW-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_q <= obt_pkg::OBT_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= hwdata[obt_pkg::OBT_CTRL_W-1:0];
        end
    end

    // sticky overflow: a new drop in the clearing cycle keeps it set
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            log_ovf_q <= 1'b0;
        end else if (log_ovf_set) begin
            log_ovf_q <= 1'b1;
        end else if (wr_status && hwdata[obt_pkg::OBT_ST_LOG_OVF]) begin
            log_ovf_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // port drive
    // ------------------------------------------------------------
    logic drive_en;
    logic dir_b_side;
    logic a_to_b_stored;
    logic b_to_a_stored;
    logic [PORT_W-1:0] port_a_out_q;
    logic [PORT_W-1:0] port_b_out_q;
    logic port_a_oe_q;
    logic port_b_oe_q;

    assign drive_en = !ctrl_q[obt_pkg::OBT_CTRL_DRIVE_EN_B];
    assign dir_b_side = ctrl_q[obt_pkg::OBT_CTRL_DIR];
    assign a_to_b_stored = ctrl_q[obt_pkg::OBT_CTRL_A_TO_B_SRC];
    assign b_to_a_stored = ctrl_q[obt_pkg::OBT_CTRL_B_TO_A_SRC];

    // both enables come from one flop stage of one control word, so they
    // can never overlap, not even for a cycle when direction flips
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            port_a_oe_q <= 1'b0;
            port_b_oe_q <= 1'b0;
        end else begin
            port_a_oe_q <= drive_en && !dir_b_side;
            port_b_oe_q <= drive_en && dir_b_side;
        end
    end

    // stored paths show an unknown register until it is first loaded
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            port_a_out_q <= '0;
            port_b_out_q <= '0;
        end else begin
            port_a_out_q <= b_to_a_stored ? b_store_q : live_b;
            port_b_out_q <= a_to_b_stored ? a_store_q : live_a;
        end
    end

    assign port_a_out = port_a_out_q;
    assign port_b_out = port_b_out_q;
    assign port_a_oe = port_a_oe_q;
    assign port_b_oe = port_b_oe_q;

    // ------------------------------------------------------------
    // capture log
    // ------------------------------------------------------------
    // a full log drops entries but never blocks a capture
    obt_buf_if #(.W(LOG_W)) log_if ();
    logic rd_log;
    logic [BW-1:0] log_word;
    logic cap_log_ready_q;

    obt_buf2 #(
        .W(LOG_W),
        .DEPTH(LOG_DEPTH)
    ) u_log (
        .clk(clk),
        .rst_b(rst_b),
        .bus(log_if.store)
    );

    // an a and a b edge in one cycle share one entry
    assign log_if.push_valid = a_capture || b_capture;
    assign log_if.push_data = {b_capture, a_capture, live_b, live_a};
    assign log_ovf_set = log_if.push_valid && !log_if.push_ready;
    assign rd_log = addr_take && !hwrite && (haddr[DW-1:0] == obt_pkg::OBT_CAPLOG_OFS);
    assign log_if.pop_ready = rd_log;

    // a flop of its own: lags the buffer by one cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cap_log_ready_q <= 1'b1;
        end else begin
            cap_log_ready_q <= log_if.push_ready;
        end
    end

    assign cap_log_ready = cap_log_ready_q;

    always_comb begin
        log_word = '0;
        log_word[LOG_W-1:0] = log_if.pop_data;
        log_word[obt_pkg::OBT_LOG_VALID_BIT] = 1'b1;
        if (!log_if.pop_valid) begin
            log_word = '0;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [obt_pkg::OBT_CTRL_W-1:0] ctrl_view;
    logic [BW-1:0] rd_word;
    logic [DW-1:0] raddr;

    // a read right behind a write to control sees the new value
    assign ctrl_view = wr_ctrl ? hwdata[obt_pkg::OBT_CTRL_W-1:0] : ctrl_q;
    assign raddr = haddr[DW-1:0];

    always_comb begin
        rd_word = '0;
        if (raddr == obt_pkg::OBT_CTRL_OFS) begin
            rd_word[obt_pkg::OBT_CTRL_W-1:0] = ctrl_view;
        end else if (raddr == obt_pkg::OBT_A_STORE_OFS) begin
            rd_word[PORT_W-1:0] = a_store_q;
        end else if (raddr == obt_pkg::OBT_B_STORE_OFS) begin
            rd_word[PORT_W-1:0] = b_store_q;
        end else if (raddr == obt_pkg::OBT_STATUS_OFS) begin
            rd_word[obt_pkg::OBT_ST_A_LOADED] = a_loaded_q;
            rd_word[obt_pkg::OBT_ST_B_LOADED] = b_loaded_q;
            rd_word[obt_pkg::OBT_ST_A_DRIVEN] = port_a_oe_q;
            rd_word[obt_pkg::OBT_ST_B_DRIVEN] = port_b_oe_q;
            rd_word[obt_pkg::OBT_ST_LOG_OVF] = log_ovf_q;
            rd_word[obt_pkg::OBT_ST_LIVE_A_LSB +: PORT_W] = live_a;
            rd_word[obt_pkg::OBT_ST_LIVE_B_LSB +: PORT_W] = live_b;
        end else if (raddr == obt_pkg::OBT_CAPLOG_OFS) begin
            rd_word = log_word;
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    // zero wait states: read data is sampled at the address edge and
    // stands through the data phase
    logic [BW-1:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hrdata_q <= '0;
        end else if (addr_take && !hwrite) begin
            hrdata_q <= rd_word;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hreadyout_q <= 1'b1;
            hresp_q <= obt_pkg::OBT_HRESP_OKAY;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q <= obt_pkg::OBT_HRESP_OKAY;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;

endmodule

`default_nettype wire

//--- common/obt_pkg.sv
// constants shared by the octal registered bus transceiver files
`default_nettype none

package obt_pkg;

    // ------------------------------------------------------------
    // data path widths
    // ------------------------------------------------------------
    localparam int OBT_PORT_W = 8;
    localparam int OBT_BUS_W = 32;
    localparam int OBT_DEC_W = 8;
    localparam int OBT_LOG_DEPTH = 2;
    // capture log entry: {b_hit, a_hit, b_data, a_data}
    localparam int OBT_LOG_W = 2 * OBT_PORT_W + 2;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [OBT_DEC_W-1:0] OBT_CTRL_OFS = 8'h00;
    localparam logic [OBT_DEC_W-1:0] OBT_A_STORE_OFS = 8'h04;
    localparam logic [OBT_DEC_W-1:0] OBT_B_STORE_OFS = 8'h08;
    localparam logic [OBT_DEC_W-1:0] OBT_STATUS_OFS = 8'h0C;
    localparam logic [OBT_DEC_W-1:0] OBT_CAPLOG_OFS = 8'h10;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int OBT_CTRL_W = 4;
    localparam int OBT_CTRL_DRIVE_EN_B = 0;
    localparam int OBT_CTRL_DIR = 1;
    localparam int OBT_CTRL_A_TO_B_SRC = 2;
    localparam int OBT_CTRL_B_TO_A_SRC = 3;
    // drive enable deasserted, direction low, both paths live
    localparam logic [OBT_CTRL_W-1:0] OBT_CTRL_RESET = 4'h1;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int OBT_ST_A_LOADED = 0;
    localparam int OBT_ST_B_LOADED = 1;
    localparam int OBT_ST_A_DRIVEN = 2;
    localparam int OBT_ST_B_DRIVEN = 3;
    localparam int OBT_ST_LOG_OVF = 4;
    localparam int OBT_ST_LIVE_A_LSB = 8;
    localparam int OBT_ST_LIVE_B_LSB = 16;

    // ------------------------------------------------------------
    // capture log read word
    // ------------------------------------------------------------
    localparam int OBT_LOG_VALID_BIT = 31;

    // ------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------
    localparam logic [1:0] OBT_HTRANS_NONSEQ = 2'h2;
    localparam logic OBT_HRESP_OKAY = 1'b0;

endpackage

`default_nettype wire

//--- common/obt_buf_if.sv
// valid/ready carrier between the transceiver core and its capture log buffer
`default_nettype none

interface obt_buf_if #(
    parameter int W = 18
);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;

    modport store (
        input push_valid,
        input push_data,
        input pop_ready,
        output push_ready,
        output pop_valid,
        output pop_data
    );

    modport user (
        output push_valid,
        output push_data,
        output pop_ready,
        input push_ready,
        input pop_valid,
        input pop_data
    );
endinterface

`default_nettype wire

//--- design/obt_buf2.sv
// small valid/ready buffer holding capture log entries
`default_nettype none

module obt_buf2 #(
    parameter int W = 18,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    obt_buf_if.store bus
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic do_push;
    logic do_pop;

    // full and empty are compares on the count flop alone, so neither ready nor valid is a long path
    assign do_push = bus.push_valid && bus.push_ready;
    assign do_pop = bus.pop_valid && bus.pop_ready;
    assign bus.push_ready = (count_q != FULL_COUNT);
    assign bus.pop_valid = (count_q != '0);
    assign bus.pop_data = mem[rd_ptr_q];

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_q] <= bus.push_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + PW'(1);
            end
            if (do_pop) begin
                rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + PW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count_q <= '0;
        end else if (do_push && !do_pop) begin
            count_q <= count_q + CW'(1);
        end else if (do_pop && !do_push) begin
            count_q <= count_q - CW'(1);
        end
    end
endmodule

`default_nettype wire

//--- verif/obt_far_bus.sv
// far-side logic model that drives both parallel buses
`default_nettype none

module obt_far_bus #(
    parameter int PORT_W = 8
) (
    input wire logic [PORT_W-1:0] far_a,
    input wire logic [PORT_W-1:0] far_b,
    input wire logic [PORT_W-1:0] port_a_out,
    input wire logic port_a_oe,
    input wire logic [PORT_W-1:0] port_b_out,
    input wire logic port_b_oe,
    output logic [PORT_W-1:0] port_a_in,
    output logic [PORT_W-1:0] port_b_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // backs off a bus once the transceiver drives it, else keeps it driven
    // so that a capture edge in isolation always sees real data
    assign port_a_in = port_a_oe ? port_a_out : far_a;
    assign port_b_in = port_b_oe ? port_b_out : far_b;
endmodule

`default_nettype wire

//--- verif/obt_transceiver_asserts.sv
// concurrent checks on the transceiver top-level ports
`default_nettype none

module obt_transceiver_asserts #(
    parameter int PORT_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic a_capture_clock,
    input wire logic b_capture_clock,
    input wire logic [PORT_W-1:0] port_a_in,
    input wire logic [PORT_W-1:0] port_a_out,
    input wire logic port_a_oe,
    input wire logic [PORT_W-1:0] port_b_in,
    input wire logic [PORT_W-1:0] port_b_out,
    input wire logic port_b_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic wr_q;
    logic [3:0] ctl_q;
    logic [3:0] ctl_age_q;
    logic [3:0] a_age_q;
    logic [3:0] b_age_q;
    logic [3:0] ca_age_q;
    logic [3:0] cb_age_q;

    function automatic logic [3:0] sat(input logic [3:0] v);
        return v + {3'h0, v != 4'hF};
    endfunction

    // --------------------------------------------------------
    // control shadow and settle counters
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_q <= 1'b0;
            ctl_q <= obt_pkg::OBT_CTRL_RESET;
        end else if (hready) begin
            wr_q <= hsel && htrans[1] && hwrite && haddr[7:0] == obt_pkg::OBT_CTRL_OFS;
            ctl_q <= wr_q ? hwdata[3:0] : ctl_q;
        end
    end

    // pins pass a three-flop path, so only judge outputs once inputs settle
    always_ff @(posedge clk) begin
        ctl_age_q <= (!rst_b || wr_q) ? 4'h0 : sat(ctl_age_q);
        a_age_q <= (!rst_b || $changed(port_a_in)) ? 4'h0 : sat(a_age_q);
        b_age_q <= (!rst_b || $changed(port_b_in)) ? 4'h0 : sat(b_age_q);
        ca_age_q <= (!rst_b || $changed(a_capture_clock)) ? 4'h0 : sat(ca_age_q);
        cb_age_q <= (!rst_b || $changed(b_capture_clock)) ? 4'h0 : sat(cb_age_q);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_ctl_read;
        hsel && hready && htrans[1] && !hwrite && haddr[7:0] == obt_pkg::OBT_CTRL_OFS;
    endsequence

    sequence s_ctl_settled;
        ctl_age_q >= 4'h8;
    endsequence

    // --------------------------------------------------------
    // assertions
    // --------------------------------------------------------
    a_one_port_driven: assert property (!(port_a_oe && port_b_oe))
        else $error("both ports driven at once");
    a_bus_okay: assert property (hreadyout && hresp == obt_pkg::OBT_HRESP_OKAY)
        else $error("bus answer not ready or not okay");
    a_drive_a: assert property (s_ctl_settled ##0 ctl_q[1:0] == 2'h0 |-> port_a_oe && !port_b_oe)
        else $error("port a not the driven port");
    a_drive_b: assert property (s_ctl_settled ##0 ctl_q[1:0] == 2'h2 |-> port_b_oe && !port_a_oe)
        else $error("port b not the driven port");
    a_isolate_quiet: assert property (s_ctl_settled ##0 ctl_q[0] |-> !port_a_oe && !port_b_oe)
        else $error("port driven while disabled");
    a_live_into_a: assert property (s_ctl_settled ##0 ((ctl_q & 4'hB) == 4'h0 && b_age_q >= 4'h5)
        |-> port_a_out == port_b_in)
        else $error("live b value not on port a");
    a_live_into_b: assert property (s_ctl_settled ##0 ((ctl_q & 4'h7) == 4'h2 && a_age_q >= 4'h5)
        |-> port_b_out == port_a_in)
        else $error("live a value not on port b");
    a_stored_b_hold: assert property (s_ctl_settled ##0 ((ctl_q & 4'hB) == 4'h8 && cb_age_q >= 4'h8)
        |=> $stable(port_a_out))
        else $error("stored b output moved without capture");
    a_stored_a_hold: assert property (s_ctl_settled ##0 ((ctl_q & 4'h7) == 4'h6 && ca_age_q >= 4'h8)
        |=> $stable(port_b_out))
        else $error("stored a output moved without capture");
    a_ctl_readback: assert property (s_ctl_read |=> hrdata[3:0] == ctl_q)
        else $error("control read returned wrong value");
endmodule

bind obt_transceiver obt_transceiver_asserts #(.PORT_W(PORT_W)) i_asserts (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .a_capture_clock(a_capture_clock), .b_capture_clock(b_capture_clock),
    .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
    .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe)
);

`default_nettype wire

//--- verif/obt_transceiver_bench.sv
// self-checking bench for the octal registered bus transceiver
`default_nettype none

module obt_transceiver_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic a_capture_clock = 1'b0;
    logic b_capture_clock = 1'b0;
    logic [7:0] far_a = 8'h00;
    logic [7:0] far_b = 8'h00;
    logic [7:0] a_in, a_out, b_in, b_out;
    logic a_oe, b_oe, log_rdy;
    int fails = 0;
    int checks_done = 0;

    obt_transceiver i_dut (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .a_capture_clock(a_capture_clock), .b_capture_clock(b_capture_clock),
        .port_a_in(a_in), .port_a_out(a_out), .port_a_oe(a_oe), .port_b_in(b_in),
        .port_b_out(b_out), .port_b_oe(b_oe), .cap_log_ready(log_rdy)
    );

    obt_far_bus i_far (
        .far_a(far_a), .far_b(far_b), .port_a_out(a_out), .port_a_oe(a_oe),
        .port_b_out(b_out), .port_b_oe(b_oe), .port_a_in(a_in), .port_b_in(b_in)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    // --------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------
    task automatic end_sim();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            fails++;
            end_sim();
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= obt_pkg::OBT_HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h0, adr};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] rd;
        xfer(1'b1, adr, wd, rd);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] rd;
        xfer(1'b0, adr, 32'h0, rd);
        chk(rd & mask, exp);
    endtask

    // waits, bounded, for the one driven port to show the value
    task automatic port_chk(input logic to_b, input logic [7:0] exp);
        int n;
        n = 0;
        while (n < 16 && (to_b ? {b_oe, a_oe, b_out} : {a_oe, b_oe, a_out}) !== {2'b10, exp}) begin
            @(posedge clk);
            n++;
        end
        checks_done++;
        if (n >= 16) begin
            fails++;
            $display("BAD %0t port never showed %h", $time, exp);
        end
    endtask

    // port data held 4 cycles either side, clock high and low 4 cycles
    task automatic capture(input logic do_a, input logic do_b);
        repeat (4) @(posedge clk);
        a_capture_clock <= do_a;
        b_capture_clock <= do_b;
        repeat (4) @(posedge clk);
        a_capture_clock <= 1'b0;
        b_capture_clock <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_reset();
        rd_chk(obt_pkg::OBT_CTRL_OFS, 32'hF, {28'h0, obt_pkg::OBT_CTRL_RESET});
        rd_chk(obt_pkg::OBT_STATUS_OFS, 32'h1F, 32'h0);
        rd_chk(8'h14, 32'hFFFFFFFF, 32'h0);
        chk({30'h0, a_oe, b_oe}, 32'h0);
    endtask

    task automatic t_isolate();
        far_a <= 8'h5A;
        far_b <= 8'hC3;
        capture(1'b1, 1'b1);
        rd_chk(obt_pkg::OBT_A_STORE_OFS, 32'hFF, 32'h5A);
        rd_chk(obt_pkg::OBT_B_STORE_OFS, 32'hFF, 32'hC3);
        rd_chk(obt_pkg::OBT_STATUS_OFS, 32'h3, 32'h3);
        far_a <= 8'hA5;
        far_b <= 8'h3C;
        wr(obt_pkg::OBT_A_STORE_OFS, 32'hFF);
        repeat (8) @(posedge clk);
        rd_chk(obt_pkg::OBT_A_STORE_OFS, 32'hFF, 32'h5A);
        rd_chk(obt_pkg::OBT_B_STORE_OFS, 32'hFF, 32'hC3);
        rd_chk(obt_pkg::OBT_CAPLOG_OFS, 32'h8003FFFF, 32'h8003C35A);
        rd_chk(obt_pkg::OBT_CAPLOG_OFS, 32'h80000000, 32'h0);
        chk({30'h0, a_oe, b_oe}, 32'h0);
    endtask

    task automatic t_live();
        wr(obt_pkg::OBT_CTRL_OFS, 32'h0);
        far_b <= 8'h81;
        port_chk(1'b0, 8'h81);
        far_b <= 8'h7E;
        port_chk(1'b0, 8'h7E);
        repeat (4) @(posedge clk);
        wr(obt_pkg::OBT_CTRL_OFS, 32'h2);
        far_a <= 8'h96;
        port_chk(1'b1, 8'h96);
        far_a <= 8'h01;
        port_chk(1'b1, 8'h01);
        rd_chk(obt_pkg::OBT_STATUS_OFS, 32'hFF0C, 32'h0108);
    endtask

    task automatic t_stored();
        wr(obt_pkg::OBT_CTRL_OFS, 32'h8);
        port_chk(1'b0, 8'hC3);
        far_b <= 8'h3C;
        capture(1'b0, 1'b1);
        port_chk(1'b0, 8'h3C);
        far_b <= 8'h77;
        repeat (8) @(posedge clk);
        port_chk(1'b0, 8'h3C);
        wr(obt_pkg::OBT_CTRL_OFS, 32'h6);
        port_chk(1'b1, 8'h5A);
        far_a <= 8'h11;
        capture(1'b1, 1'b0);
        port_chk(1'b1, 8'h11);
        far_a <= 8'h44;
        repeat (8) @(posedge clk);
        port_chk(1'b1, 8'h11);
    endtask

    task automatic t_log();
        logic [31:0] rd;
        int n;
        wr(obt_pkg::OBT_CTRL_OFS, 32'h1);
        n = 0;
        do begin
            xfer(1'b0, obt_pkg::OBT_CAPLOG_OFS, 32'h0, rd);
            n++;
        end while (rd[31] === 1'b1 && n < 4);
        wr(obt_pkg::OBT_STATUS_OFS, 32'h10);
        rd_chk(obt_pkg::OBT_STATUS_OFS, 32'h10, 32'h0);
        chk({31'h0, log_rdy}, 32'h1);
        far_a <= 8'h21;
        capture(1'b1, 1'b0);
        far_a <= 8'h22;
        capture(1'b1, 1'b0);
        chk({31'h0, log_rdy}, 32'h0);
        far_a <= 8'h23;
        capture(1'b1, 1'b0);
        rd_chk(obt_pkg::OBT_STATUS_OFS, 32'h10, 32'h10);
        rd_chk(obt_pkg::OBT_CAPLOG_OFS, 32'h800300FF, 32'h80010021);
        rd_chk(obt_pkg::OBT_CAPLOG_OFS, 32'h800300FF, 32'h80010022);
        rd_chk(obt_pkg::OBT_CAPLOG_OFS, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, log_rdy}, 32'h1);
        wr(obt_pkg::OBT_STATUS_OFS, 32'h10);
        rd_chk(obt_pkg::OBT_STATUS_OFS, 32'h10, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_isolate();
        t_live();
        t_stored();
        t_log();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim();
    end
endmodule

`default_nettype wire
